/* include/stb_regs.vh */
// register map, field positions, reset values and divider counts of the timer unit
`ifndef STB_REGS_VH
`define STB_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// byte addresses on the apb bus
`define STB_ADDR_START_A 8'h00
`define STB_ADDR_START_B 8'h04
`define STB_ADDR_IRQ_STAT 8'h08
`define STB_ADDR_IRQ_MASK 8'h0C
// timer i: mode at 8'h10 + 8*i, counter at 8'h14 + 8*i
`define STB_CH_FIRST 3'h2
`define STB_CH_LAST 3'h7

////////////////////////////////////////////////////////////////////////////////
// timer_mode_reg fields
`define STB_OP_LSB 0
`define STB_OP_MSB 1
`define STB_SEL_LO0 2
`define STB_SEL_LO1 3
`define STB_SEL_HI 4
`define STB_OVF 5
`define STB_SRC_LSB 6
`define STB_SRC_MSB 7

// operation modes
`define STB_OP_TIMER 2'h0
`define STB_OP_EVENT 2'h1
`define STB_OP_MEAS 2'h2

// measurement selections (measure_select_lo1, measure_select_lo0)
`define STB_MEAS_PER_FALL 2'h0
`define STB_MEAS_PER_RISE 2'h1
`define STB_MEAS_WIDTH 2'h2

////////////////////////////////////////////////////////////////////////////////
// reset values and special read values
`define STB_MODE_RST 8'h00
`define STB_CNT_RST 16'h0000
`define STB_CNT_MAX 16'hFFFF
`define STB_RELOAD_READ 16'hFFFF
`define STB_WORD_ZERO 32'h0000_0000

////////////////////////////////////////////////////////////////////////////////
// count source divider: a tick fires when the masked bits are all ones
`define STB_DIV_W 6
`define STB_DIV8_MASK 6'h07
`define STB_DIV32_MASK 6'h1F
`define STB_DIV64_MASK 6'h3F

`endif

/* rtl/stb_sync.v */
// two flip-flop synchroniser for external pins
`timescale 1ns/1ns
module stb_sync #(
    parameter W = 6
) (
    input wire I_CLK, // system clock
    input wire I_NRST, // synchronous reset, active low
    input wire [W-1:0] i_async, // pin levels from outside
    output wire [W-1:0] o_sync // levels safe to use
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    ////////////////////////////////////////////////////////////////////////////
    // first stage feeds only the second one
    always @(posedge I_CLK) begin
        if (!I_NRST) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule // stb_sync

/* rtl/stb_presc.v */
// free running divider giving the four count source tick enables
`timescale 1ns/1ns
`include "stb_regs.vh"
module stb_presc (
    input wire I_CLK, // system clock
    input wire I_NRST, // synchronous reset, active low
    output wire [3:0] o_tick // one-cycle enables: /1, /8, /32, /64
);
    reg [`STB_DIV_W-1:0] div_q;
    wire [`STB_DIV_W-1:0] div_d;

    ////////////////////////////////////////////////////////////////////////////
    // one shared counter serves all six timers so their ticks stay aligned
    assign div_d = div_q + {{(`STB_DIV_W-1){1'b0}}, 1'b1};

    always @(posedge I_CLK) begin
        if (!I_NRST) begin
            div_q <= {`STB_DIV_W{1'b0}};
        end else begin
            div_q <= div_d;
        end
    end

    // decode enables from the low counter bits
    assign o_tick[0] = 1'b1;
    assign o_tick[1] = (div_q & `STB_DIV8_MASK) == `STB_DIV8_MASK;
    assign o_tick[2] = (div_q & `STB_DIV32_MASK) == `STB_DIV32_MASK;
    assign o_tick[3] = (div_q & `STB_DIV64_MASK) == `STB_DIV64_MASK;
endmodule // stb_presc

/* rtl/stb_top.v */
// six 16-bit timers with timer, event counter and pulse measurement modes on apb
//
// What this block does
// - timers stay stopped after reset; each runs only while its start bit is 1
// - outside measurement, counter read returns live count, or FFFF when read during a reload
// - counter written while stopped reads back the written value until start
// - measurement mode raises the interrupt on an effective edge or an overflow
// - overflow flag is readable in the mode register during measurement
// - writing mode with start 1 clears overflow only after the next tick
// - first edge after start loads an arbitrary capture and raises no interrupt
// - counter is not cleared at start, so early overflow and interrupt may occur
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ns
`include "stb_regs.vh"
module stb_top (
    input wire I_CLK, // system clock, 25 mhz
    input wire I_NRST, // synchronous reset, active low
    input wire I_PSEL, // apb select
    input wire I_PENABLE, // apb access phase
    input wire I_PWRITE, // apb direction, high for write
    input wire [7:0] I_PADDR, // apb byte address
    input wire [31:0] I_PWDATA, // apb write data
    output wire [31:0] O_PRDATA, // apb read data
    output wire O_PREADY, // apb ready, always high
    output wire O_PSLVERR, // apb error on unmapped address
    input wire [5:0] I_EVT_IN, // event count inputs, one per timer
    input wire [5:0] I_MEAS_IN, // measured pulse inputs, one per timer
    output wire O_IRQ // level interrupt, high while unmasked flag set
);

    ////////////////////////////////////////////////////////////////////////////
    // apb decode
    wire wr_acc;
    wire rd_setup;
    wire ch_hit;
    wire [2:0] ch_sel;
    wire ch_cnt;
    wire hit;
    wire hit_start_a;
    wire hit_start_b;
    wire hit_stat;
    wire hit_mask;

    // writes take effect at the access edge; the slave never stretches it
    assign wr_acc = I_PSEL & I_PENABLE & I_PWRITE;
    assign rd_setup = I_PSEL & ~I_PENABLE & ~I_PWRITE;

    // channel area: bits 5:3 pick the timer, bit 2 picks counter over mode
    assign ch_hit = (I_PADDR[7:6] == 2'b00) && (I_PADDR[1:0] == 2'b00) &&
                    (I_PADDR[5:3] >= `STB_CH_FIRST) && (I_PADDR[5:3] <= `STB_CH_LAST);
    assign ch_sel = I_PADDR[5:3] - `STB_CH_FIRST;
    assign ch_cnt = I_PADDR[2];

    assign hit_start_a = (I_PADDR == `STB_ADDR_START_A);
    assign hit_start_b = (I_PADDR == `STB_ADDR_START_B);
    assign hit_stat = (I_PADDR == `STB_ADDR_IRQ_STAT);
    assign hit_mask = (I_PADDR == `STB_ADDR_IRQ_MASK);
    assign hit = ch_hit | hit_start_a | hit_start_b | hit_stat | hit_mask;

    // zero wait states; an error answer leaves all state untouched
    assign O_PREADY = 1'b1;
    assign O_PSLVERR = I_PSEL & I_PENABLE & ~hit;

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers and edge detection
    wire [5:0] evt_s;
    wire [5:0] meas_s;
    reg [5:0] evt_d_q;
    reg [5:0] meas_d_q;
    wire [5:0] evt_rise;
    wire [5:0] evt_fall;
    wire [5:0] meas_rise;
    wire [5:0] meas_fall;
    wire [3:0] tick_en;

    stb_sync #(.W(6)) u_sync_evt (
        .I_CLK(I_CLK),
        .I_NRST(I_NRST),
        .i_async(I_EVT_IN),
        .o_sync(evt_s)
    );

    stb_sync #(.W(6)) u_sync_meas (
        .I_CLK(I_CLK),
        .I_NRST(I_NRST),
        .i_async(I_MEAS_IN),
        .o_sync(meas_s)
    );

    stb_presc u_presc (
        .I_CLK(I_CLK),
        .I_NRST(I_NRST),
        .o_tick(tick_en)
    );

    // previous synchronised level for edge detection
    always @(posedge I_CLK) begin
        if (!I_NRST) begin
            evt_d_q <= 6'h00;
            meas_d_q <= 6'h00;
        end else begin
            evt_d_q <= evt_s;
            meas_d_q <= meas_s;
        end
    end

    assign evt_rise = evt_s & ~evt_d_q;
    assign evt_fall = ~evt_s & evt_d_q;
    assign meas_rise = meas_s & ~meas_d_q;
    assign meas_fall = ~meas_s & meas_d_q;

    ////////////////////////////////////////////////////////////////////////////
    // shared start registers, status and mask
    reg [2:0] start_a_q;
    reg [2:0] start_b_q;
    reg [5:0] stat_q;
    reg [5:0] mask_q;
    reg irq_q;
    wire [5:0] run;
    wire [5:0] irq_ev;
    wire [5:0] stat_clr;

    assign run = {start_b_q, start_a_q};

    // start bits come up cleared so every timer idles after reset
    always @(posedge I_CLK) begin
        if (!I_NRST) begin
            start_a_q <= 3'h0;
            start_b_q <= 3'h0;
            mask_q <= 6'h00;
        end else if (wr_acc) begin
            if (hit_start_a) begin
                start_a_q <= I_PWDATA[2:0];
            end
            if (hit_start_b) begin
                start_b_q <= I_PWDATA[2:0];
            end
            if (hit_mask) begin
                mask_q <= I_PWDATA[5:0];
            end
        end
    end

    // write one clears; a new request in the same cycle wins over the clear
    assign stat_clr = (wr_acc && hit_stat) ? I_PWDATA[5:0] : 6'h00;

    always @(posedge I_CLK) begin
        if (!I_NRST) begin
            stat_q <= 6'h00;
            irq_q <= 1'b0;
        end else begin
            stat_q <= (stat_q & ~stat_clr) | irq_ev;
            irq_q <= |(stat_q & mask_q);
        end
    end

    assign O_IRQ = irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // the six timer channels
    wire [47:0] mode_rd;
    wire [95:0] cnt_rd;

    genvar i;
    generate
        for (i = 0; i < 6; i = i + 1) begin : g_ch
            localparam [2:0] IDX = i;
            reg [7:0] mode_q;
            reg [15:0] cnt_q;
            reg [15:0] rld_q;
            reg ovf_q;
            reg clr_pend_q;
            reg seen_q;
            wire wr_mode;
            wire wr_cnt;
            wire [1:0] op;
            wire [1:0] msel;
            wire meas;
            wire evt_edge;
            wire meas_edge;
            wire tick;
            wire zero;
            wire full;
            wire reload;
            wire ovf_set;

            assign wr_mode = wr_acc && ch_hit && (ch_sel == IDX) && !ch_cnt;
            assign wr_cnt = wr_acc && ch_hit && (ch_sel == IDX) && ch_cnt;
            assign op = mode_q[`STB_OP_MSB:`STB_OP_LSB];
            assign msel = {mode_q[`STB_SEL_LO1], mode_q[`STB_SEL_LO0]};
            assign meas = (op == `STB_OP_MEAS);

            // event mode: lo1 counts both edges, else lo0 picks rising
            assign evt_edge = mode_q[`STB_SEL_LO1] ? (evt_rise[i] | evt_fall[i]) :
                              mode_q[`STB_SEL_LO0] ? evt_rise[i] : evt_fall[i];

            // width mode ends a measurement on every edge, so high and low
            // widths alternate and software has to track which is which
            assign meas_edge = (msel == `STB_MEAS_WIDTH) ? (meas_rise[i] | meas_fall[i]) :
                               (msel == `STB_MEAS_PER_RISE) ? meas_rise[i] :
                               meas_fall[i];

            // event mode counts pin edges; other modes count divider ticks
            assign tick = (op == `STB_OP_EVENT) ? evt_edge :
                          tick_en[mode_q[`STB_SRC_MSB:`STB_SRC_LSB]];

            assign zero = (cnt_q == `STB_CNT_RST);
            assign full = (cnt_q == `STB_CNT_MAX);
            assign reload = run[i] && !meas && tick && zero;
            assign ovf_set = run[i] && meas && tick && full && !meas_edge;

            // request sources: underflow, or edge and overflow when measuring
            assign irq_ev[i] = reload |
                               (run[i] && meas && ((meas_edge && seen_q) || ovf_set));

            // mode register; fields only change while stopped
            always @(posedge I_CLK) begin
                if (!I_NRST) begin
                    mode_q <= `STB_MODE_RST;
                    clr_pend_q <= 1'b0;
                end else begin
                    if (wr_mode && !run[i]) begin
                        mode_q <= I_PWDATA[7:0];
                        clr_pend_q <= 1'b0;
                    end else if (wr_mode && meas && !I_PWDATA[`STB_OVF]) begin
                        // running write only arms the overflow clear
                        clr_pend_q <= 1'b1;
                    end else if (tick && run[i]) begin
                        clr_pend_q <= 1'b0;
                    end
                end
            end

            // overflow flag; the clear waits for the following tick, and
            // an overflow on that same tick keeps the flag set
            always @(posedge I_CLK) begin
                if (!I_NRST) begin
                    ovf_q <= 1'b0;
                end else if (wr_mode && !run[i]) begin
                    ovf_q <= 1'b0;
                end else if (ovf_set || (run[i] && meas && tick && full)) begin
                    ovf_q <= 1'b1;
                end else if (run[i] && tick && clr_pend_q) begin
                    ovf_q <= 1'b0;
                end
            end

            // first edge after a start is not reported
            always @(posedge I_CLK) begin
                if (!I_NRST) begin
                    seen_q <= 1'b0;
                end else if (!run[i]) begin
                    seen_q <= 1'b0;
                end else if (meas && meas_edge) begin
                    seen_q <= 1'b1;
                end
            end

            // counter and reload register
            always @(posedge I_CLK) begin
                if (!I_NRST) begin
                    cnt_q <= `STB_CNT_RST;
                    rld_q <= `STB_CNT_RST;
                end else if (!run[i]) begin
                    if (wr_cnt) begin
                        cnt_q <= I_PWDATA[15:0];
                        rld_q <= I_PWDATA[15:0];
                    end
                end else if (meas) begin
                    // count is left as found at start, so it may wrap early
                    if (meas_edge) begin
                        rld_q <= cnt_q;
                        cnt_q <= `STB_CNT_RST;
                    end else if (tick) begin
                        cnt_q <= cnt_q + 16'h0001;
                    end
                end else begin
                    if (wr_cnt) begin
                        rld_q <= I_PWDATA[15:0];
                    end
                    if (reload) begin
                        cnt_q <= rld_q;
                    end else if (tick) begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
            end

            // read views; a read during a reload sees all ones
            assign mode_rd[8*i+7:8*i] = {mode_q[`STB_SRC_MSB:`STB_SRC_LSB], ovf_q,
                                         mode_q[`STB_SEL_HI:0]};
            assign cnt_rd[16*i+15:16*i] = meas ? rld_q :
                                          reload ? `STB_RELOAD_READ : cnt_q;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // read mux and registered read data
    reg [31:0] rd_mux;
    reg [31:0] prdata_q;

    always @* begin
        rd_mux = `STB_WORD_ZERO;
        if (hit_start_a) begin
            rd_mux = {29'h0000_0000, start_a_q};
        end else if (hit_start_b) begin
            rd_mux = {29'h0000_0000, start_b_q};
        end else if (hit_stat) begin
            rd_mux = {26'h000_0000, stat_q};
        end else if (hit_mask) begin
            rd_mux = {26'h000_0000, mask_q};
        end else if (ch_hit && ch_cnt) begin
            rd_mux = {16'h0000, cnt_rd[16*ch_sel +: 16]};
        end else if (ch_hit) begin
            rd_mux = {24'h00_0000, mode_rd[8*ch_sel +: 8]};
        end
    end

    // sampled in the setup cycle, held through the access phase
    always @(posedge I_CLK) begin
        if (!I_NRST) begin
            prdata_q <= `STB_WORD_ZERO;
        end else if (rd_setup) begin
            prdata_q <= rd_mux;
        end
    end

    assign O_PRDATA = prdata_q;

endmodule // stb_top

/* dv/stb_chk_asserts.sv */
// port assertions of the six channel timer unit
`timescale 1ns/1ns
module stb_chk (
    input wire I_CLK, // system clock
    input wire I_NRST, // synchronous reset, active low
    input wire I_PSEL, // apb select
    input wire I_PENABLE, // apb access phase
    input wire I_PWRITE, // apb direction
    input wire [7:0] I_PADDR, // apb byte address
    input wire [31:0] I_PWDATA, // apb write data
    input wire [31:0] O_PRDATA, // apb read data
    input wire O_PREADY, // apb ready
    input wire O_PSLVERR, // apb error
    input wire [5:0] I_EVT_IN, // event pins
    input wire [5:0] I_MEAS_IN, // pulse pins
    input wire O_IRQ // interrupt line
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_NRST);
    logic [5:0] mask_q;
    logic run_q;
    wire acc = I_PSEL && I_PENABLE;
    wire wr_acc = acc && I_PWRITE;
    wire rd_setup = I_PSEL && !I_PENABLE && !I_PWRITE;
    ////////////////////////////////////////////////////////////////////////////////
    // shadow of mask and start writes, so the interrupt can be tied to its cause
    always @(posedge I_CLK) begin
        if (!I_NRST) begin
            mask_q <= 6'h00;
            run_q <= 1'b0;
        end else begin
            if (wr_acc && I_PADDR == 8'h0C) mask_q <= I_PWDATA[5:0];
            if (wr_acc && I_PADDR <= 8'h04 && I_PWDATA[2:0] != 3'h0) run_q <= 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    property p_ready; O_PREADY; endproperty
    a_ready: assert property (p_ready) else $error("ready dropped");
    property p_err_unmap; acc && I_PADDR > 8'h3C |-> O_PSLVERR; endproperty
    a_err_unmap: assert property (p_err_unmap) else $error("no error on unmapped access");
    property p_err_map; acc && I_PADDR <= 8'h3C && I_PADDR[1:0] == 2'b00 |-> !O_PSLVERR;
    endproperty
    a_err_map: assert property (p_err_map) else $error("error on mapped access");
    property p_err_idle; !acc |-> !O_PSLVERR; endproperty
    a_err_idle: assert property (p_err_idle) else $error("error outside access phase");
    property p_rd_hold; !rd_setup |=> $stable(O_PRDATA); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
    property p_rd_unmap; rd_setup && I_PADDR > 8'h3C |=> O_PRDATA == 32'h0000_0000; endproperty
    a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read not zero");
    property p_rd_rst; disable iff (1'b0) !I_NRST |=> O_PRDATA == 32'h0000_0000; endproperty
    a_rd_rst: assert property (p_rd_rst) else $error("read data not cleared by reset");
    property p_irq_rst; disable iff (1'b0) !I_NRST |=> !O_IRQ; endproperty
    a_irq_rst: assert property (p_irq_rst) else $error("interrupt high after reset");
    property p_irq_mask; mask_q == 6'h00 |=> !O_IRQ; endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("interrupt while all masked");
    property p_irq_idle; !run_q |=> !O_IRQ; endproperty
    a_irq_idle: assert property (p_irq_idle) else $error("interrupt before any start");
    c_irq: cover property ($rose(O_IRQ));
    c_err: cover property (acc && O_PSLVERR);
    c_start: cover property (wr_acc && I_PADDR == 8'h04 && I_PWDATA[2:0] != 3'h0);
endmodule // stb_chk

bind stb_top stb_chk u_chk (.I_CLK(I_CLK), .I_NRST(I_NRST), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
    .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
    .I_EVT_IN(I_EVT_IN), .I_MEAS_IN(I_MEAS_IN), .O_IRQ(O_IRQ));

/* dv/stb_pin_model.sv */
// square wave source for the event and measured pulse pins
`timescale 1ns/1ns
module stb_pin_model (
    input wire i_clk, // system clock
    input wire [5:0] i_en, // pins that toggle, the rest hold their level
    input wire [7:0] i_half, // half period in clocks
    output logic [5:0] o_pins // pin levels
);
    logic [7:0] cnt_q = 8'h00;
    initial o_pins = 6'h00;
    // free running phase, so a start write lands anywhere within a period
    always @(posedge i_clk) begin
        if (cnt_q + 8'h01 >= i_half) begin
            cnt_q <= 8'h00;
            o_pins <= o_pins ^ i_en; // (high and low widths follow back to back)
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule // stb_pin_model

/* dv/stb_tb.sv */
// self-checking bench of the six channel timer unit
`timescale 1ns/1ns
`include "stb_regs.vh"
module testbench;
    typedef struct {string nm; logic [32:0] e; logic [32:0] m;} stb_exp_t;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [5:0] evt_en = 6'h00;
    logic [5:0] meas_en = 6'h00;
    logic [15:0] val;
    wire [31:0] prdata;
    wire pready, pslverr, irq;
    wire [5:0] evt_pins, meas_pins;
    int err_count = 0;
    int cmp_count = 0;
    int k;
    stb_exp_t exp_q[$];
    stb_exp_t mon_n;
    stb_top dut_u (.I_CLK(clk), .I_NRST(nrst), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_EVT_IN(evt_pins),
        .I_MEAS_IN(meas_pins), .O_IRQ(irq));
    stb_pin_model u_evt (.i_clk(clk), .i_en(evt_en), .i_half(8'h04), .o_pins(evt_pins));
    stb_pin_model u_meas (.i_clk(clk), .i_en(meas_en), .i_half(8'h18), .o_pins(meas_pins));
    initial forever #20 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // one apb transfer; the note is queued first so the monitor always finds it
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
            input logic [31:0] e, input logic [31:0] m);
        stb_exp_t n;
        n.nm = $sformatf("reg_%h", a);
        n.e = {a > 8'h3C, e};
        n.m = {1'b1, w ? 32'h0000_0000 : m};
        exp_q.push_back(n);
        psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        // no own limit: a slave that never answers is caught by the watchdog
        while (pready !== 1'b1) @(posedge clk);
        psel <= 1'b0; pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d, 32'h0000_0000, 32'h0000_0000);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        apb(a, 1'b0, 32'h0000_0000, e, m);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // monitor: every finished transfer takes the oldest note
    always @(posedge clk) begin
        if (psel && pen && pready === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("unplanned_transfer", 33'h0_0000_0000, 33'h1_FFFF_FFFF);
            end else begin
                mon_n = exp_q.pop_front();
                chk(mon_n.nm, {pslverr, prdata} & mon_n.m, mon_n.e & mon_n.m);
            end
        end
    end
    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        test_done();
    end
    initial begin
        void'($urandom(68209));
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        for (int a = 0; a < 'h48; a += 4) rd(8'(a), 32'h0000_0000, 32'hFFFF_FFFF);
        $display("test reset values done");
        for (int i = 0; i < 6; i++) begin
            val = 16'($urandom());
            wr(8'(8'h14 + 8 * i), {16'h0000, val});
            rd(8'(8'h14 + 8 * i), {16'h0000, val}, 32'h0000_FFFF);
        end
        $display("test stopped counter readback done");
        val = 16'(100 + $urandom_range(100));
        wr(8'h10, `STB_WORD_ZERO);
        wr(8'h14, {16'h0000, val});
        wr(`STB_ADDR_IRQ_MASK, 32'h0000_003F);
        wr(`STB_ADDR_START_A, 32'h0000_0001);
        repeat (90) @(posedge clk);
        chk("irq_early", {32'h0000_0000, irq}, 33'h0_0000_0000);
        for (k = 0; k < 300 && irq !== 1'b1; k++) @(posedge clk);
        chk("irq_underflow", {32'h0000_0000, irq}, 33'h0_0000_0001);
        rd(`STB_ADDR_IRQ_STAT, 32'h0000_0001, 32'h0000_003F);
        wr(8'h10, 32'h0000_0041);
        rd(8'h10, `STB_WORD_ZERO, 32'h0000_00FF);
        wr(`STB_ADDR_IRQ_MASK, `STB_WORD_ZERO);
        // the interrupt is registered: let the edge after the mask write settle it
        @(posedge clk);
        chk("irq_masked", {32'h0000_0000, irq}, 33'h0_0000_0000);
        rd(`STB_ADDR_IRQ_STAT, 32'h0000_0001, 32'h0000_003F);
        wr(`STB_ADDR_IRQ_STAT, 32'h0000_0001);
        rd(`STB_ADDR_IRQ_STAT, `STB_WORD_ZERO, 32'h0000_003F);
        $display("test timer mode done");
        // reload of zero makes every tick a reload, so any read meets one
        wr(8'h18, `STB_WORD_ZERO);
        wr(8'h1C, `STB_WORD_ZERO);
        wr(`STB_ADDR_START_A, 32'h0000_0002);
        rd(8'h1C, {16'h0000, `STB_RELOAD_READ}, 32'h0000_FFFF);
        rd(`STB_ADDR_IRQ_STAT, 32'h0000_0002, 32'h0000_0002);
        wr(8'h20, 32'h0000_0005);
        wr(8'h24, 32'h0000_0003);
        wr(`STB_ADDR_START_A, 32'h0000_0004);
        repeat (20) @(posedge clk);
        rd(`STB_ADDR_IRQ_STAT, `STB_WORD_ZERO, 32'h0000_0004);
        evt_en <= 6'h04;
        repeat (60) @(posedge clk);
        rd(`STB_ADDR_IRQ_STAT, 32'h0000_0004, 32'h0000_0004);
        wr(`STB_ADDR_START_A, `STB_WORD_ZERO);
        $display("test reload read and event mode done");
        wr(8'h28, 32'h0000_000A);
        wr(8'h2C, `STB_WORD_ZERO);
        meas_en <= 6'h08;
        @(posedge meas_pins[3]);
        @(posedge clk);
        wr(`STB_ADDR_START_B, 32'h0000_0001);
        repeat (30) @(posedge clk);
        rd(`STB_ADDR_IRQ_STAT, `STB_WORD_ZERO, 32'h0000_0008);
        repeat (100) @(posedge clk);
        rd(8'h2C, 32'h0000_0010, 32'h0000_FFF0);
        rd(`STB_ADDR_IRQ_STAT, 32'h0000_0008, 32'h0000_0008);
        wr(`STB_ADDR_START_B, `STB_WORD_ZERO);
        $display("test width measurement done");
        wr(8'h30, 32'h0000_00C2);
        wr(8'h34, 32'h0000_FFF0);
        wr(`STB_ADDR_IRQ_MASK, 32'h0000_0010);
        // timer 4 gets no pulse edges, so the flag has one source only
        wr(`STB_ADDR_START_B, 32'h0000_0002);
        repeat (1300) @(posedge clk);
        rd(8'h30, 32'h0000_00E2, 32'h0000_00FF);
        chk("irq_overflow", {32'h0000_0000, irq}, 33'h0_0000_0001);
        wr(8'h30, 32'h0000_00C2);
        repeat (140) @(posedge clk);
        rd(8'h30, 32'h0000_00C2, 32'h0000_00FF);
        wr(`STB_ADDR_IRQ_STAT, 32'h0000_003F);
        repeat (2) @(posedge clk);
        chk("irq_cleared", {32'h0000_0000, irq}, 33'h0_0000_0000);
        $display("test overflow flag done");
        test_done();
    end
endmodule // testbench
